//--- hw/ccs_core.v
// Core sequencing: configuration, oscillator trim, program counter
// and return stack. Assumes a decoder supplies one op per cycle and
// that core_clk is the oscillator; pins are sampled through synchronisers.
`timescale 1ns/1ns
`include "ccs_consts.vh"

module ccs_core #(
   parameter PCW = 9
) (
   // Clock, reset, enable
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   // Decoded instruction
   input wire instr_step,
   input wire [2:0] instr_op,
   input wire [PCW-1:0] instr_target,
   input wire [7:0] work_reg,
   input wire [7:0] instr_literal,
   // Data bus for the trim and pc low byte registers
   input wire data_wr,
   input wire [7:0] data_addr,
   input wire [7:0] data_wdata,
   output reg [7:0] data_rdata,
   // Pin direction register and pins
   input wire [3:0] pin_direction,
   input wire [3:0] port_latch,
   input wire [3:0] pin_in,
   // Program counter and literal return
   output reg [PCW-1:0] pc,
   output reg work_load,
   output reg [7:0] work_literal,
   // Pin control
   output wire [3:0] pin_out,
   output wire [3:0] pin_oe,
   output wire [3:0] pull_up_en,
   output wire [3:0] wake_en,
   output wire [3:0] pin_sync,
   // Timer and watchdog configuration
   output wire timer_source_select,
   output wire timer_edge_select,
   output wire prescaler_assign,
   output wire [2:0] prescaler_rate,
   output wire [3:0] timer_ratio_log2,
   output wire [3:0] watchdog_ratio_log2,
   output wire timer_ext_clock,
   // Oscillator trim
   output wire [6:0] trim_code,
   output wire signed [7:0] trim_offset,
   output wire clock_out_select
);
   reg [7:0] core_configuration; // Write-only, not data mapped
   reg [7:0] oscillator_trim; // Trim and clock out select
   reg [3:0] pin_meta; // First synchroniser stage
   reg [3:0] pin_stable; // Second synchroniser stage
   reg [1:0] div_cnt; // Fosc/4 divider
   reg cycle_clk; // Instruction cycle clock
   reg [PCW-1:0] next_pc; // Program counter next value
   wire [PCW-1:0] pc_plus1; // Incremented counter
   wire [PCW-1:0] stack_top; // Return address on top
   wire push; // Call pushes
   wire pop; // Return pops
   wire do_step; // Instruction executes this cycle
   wire pcl_write; // Data bus write to pc low byte
   wire trim_write; // Data bus write to trim register
   wire [3:0] pin_drives; // Pin output enable is on

   assign do_step = clk_en & instr_step;
   assign pc_plus1 = pc + {{(PCW-1){1'b0}}, 1'b1};
   assign pcl_write = data_wr & (data_addr == `CCS_ADDR_PCL);
   assign trim_write = data_wr & (data_addr == `CCS_ADDR_TRIM);

   // Stack moves only on call or return; no status flags exist
   assign push = do_step & (instr_op == `CCS_OP_CALL);
   assign pop = do_step & (instr_op == `CCS_OP_RETLIT);

   // Return stack; width follows the counter
   ccs_stack #(
      .PCW(PCW)
   ) u_stack (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .push(push),
      .pop(pop),
      .push_data(pc_plus1),
      .top(stack_top)
   );

   // Configuration register: only the load instruction writes it
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_configuration <= `CCS_CFG_RESET;
      end else if (do_step && instr_op == `CCS_OP_CFGLD) begin
         core_configuration <= work_reg;
      end
   end

   // Trim register; software keeps it once calibrated
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oscillator_trim <= `CCS_TRIM_RESET;
      end else if (clk_en && trim_write) begin
         oscillator_trim <= data_wdata;
      end
   end

   // Counter next value; a data write to the low byte counts as one
   always @* begin
      next_pc = pc_plus1;
      if (do_step) begin
         case (instr_op)
            `CCS_OP_JUMP: begin
               next_pc = instr_target;
            end
            `CCS_OP_CALL: begin
               next_pc = {{(PCW-8){1'b0}}, instr_target[7:0]};
            end
            `CCS_OP_RETLIT: begin
               next_pc = stack_top;
            end
            `CCS_OP_PCLWR: begin
               next_pc = {{(PCW-8){1'b0}}, data_wdata};
            end
            default: begin
               next_pc = pc_plus1;
            end
         endcase
      end
      if (pcl_write) begin
         next_pc = {{(PCW-8){1'b0}}, data_wdata};
      end
   end

   // Program counter; reset starts at the last location, then wraps
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc <= {PCW{1'b1}};
      end else if (clk_en && (instr_step || pcl_write)) begin
         pc <= next_pc;
      end
   end

   // Literal return loads the working register
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         work_load <= 1'b0;
         work_literal <= 8'h00;
      end else if (clk_en) begin
         work_load <= pop;
         if (pop) begin
            work_literal <= instr_literal;
         end
      end
   end

   // Read mux for data mapped registers; others read zero
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_rdata <= 8'h00;
      end else if (clk_en) begin
         if (data_addr == `CCS_ADDR_TRIM) begin
            data_rdata <= oscillator_trim;
         end else if (data_addr == `CCS_ADDR_PCL) begin
            data_rdata <= pc[7:0];
         end else begin
            data_rdata <= 8'h00;
         end
      end
   end

   // Pin synchroniser; only the second stage is used downstream
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_meta <= 4'h0;
         pin_stable <= 4'h0;
      end else if (clk_en) begin
         pin_meta <= pin_in;
         pin_stable <= pin_meta;
      end
   end
   assign pin_sync = pin_stable;

   // Fosc/4 cycle clock for the clock output
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 2'h0;
         cycle_clk <= 1'b0;
      end else if (clk_en) begin
         div_cnt <= div_cnt + 2'h1;
         if (div_cnt == `CCS_CLK_HALF || div_cnt == `CCS_CLK_DIV) begin
            cycle_clk <= ~cycle_clk;
         end
      end
   end

   // Configuration fields
   assign timer_source_select = core_configuration[`CCS_CFG_TSRC];
   assign timer_edge_select = core_configuration[`CCS_CFG_TEDGE];
   assign prescaler_assign = core_configuration[`CCS_CFG_PSA];
   assign prescaler_rate =
      core_configuration[`CCS_CFG_RATE_HI:`CCS_CFG_RATE_LO];
   // Timer ratio 2^(code+1), watchdog 2^code
   assign timer_ratio_log2 = {1'b0, prescaler_rate} + 4'h1;
   assign watchdog_ratio_log2 = {1'b0, prescaler_rate};
   // External edge, inverted for falling edge select
   assign timer_ext_clock = pin_stable[`CCS_PIN_CLK] ^ timer_edge_select;

   // Trim fields; offset is the code sign-extended, so code 0 is the centre
   assign trim_code = oscillator_trim[`CCS_TRIM_CAL_HI:`CCS_TRIM_CAL_LO];
   assign trim_offset = {trim_code[6], trim_code};
   assign clock_out_select = oscillator_trim[`CCS_TRIM_CLKO];

   // Pin drivers: pin 3 input only, pin 2 has layered overrides
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         if (gi == `CCS_PIN_CLK) begin : g_clk
            // Clock out wins, then timer input, then direction
            assign pin_out[gi] = clock_out_select ? cycle_clk
               : port_latch[gi];
            assign pin_oe[gi] = clock_out_select
               | (~timer_source_select & ~pin_direction[gi]);
            assign pin_drives[gi] = pin_oe[gi];
         end else if (gi == 3) begin : g_in
            assign pin_out[gi] = 1'b0;
            assign pin_oe[gi] = 1'b0;
            assign pin_drives[gi] = 1'b0;
         end else begin : g_io
            assign pin_out[gi] = port_latch[gi];
            assign pin_oe[gi] = ~pin_direction[gi];
            assign pin_drives[gi] = ~pin_direction[gi];
         end
         // Wake and pull-up only on pins 0, 1, 3 and never when driving
         if (gi == `CCS_PIN_CLK) begin : g_nowp
            assign wake_en[gi] = 1'b0;
            assign pull_up_en[gi] = 1'b0;
         end else begin : g_wp
            assign wake_en[gi] = ~core_configuration[`CCS_CFG_WAKE]
               & ~pin_drives[gi];
            assign pull_up_en[gi] = ~core_configuration[`CCS_CFG_PULL]
               & ~pin_drives[gi];
         end
      end
   endgenerate
endmodule

//--- hw/ccs_consts.vh
// Constants for the core sequencing and configuration block.
// Assumes plain Verilog-2005 tools; included by bare name.
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
// Data address of the oscillator trim register
`define CCS_ADDR_TRIM 8'h05
// Data address of the program counter low byte
`define CCS_ADDR_PCL 8'h02
// Reset values
`define CCS_CFG_RESET 8'hFF
`define CCS_TRIM_RESET 8'hFE
// Configuration field positions
`define CCS_CFG_WAKE 7
`define CCS_CFG_PULL 6
`define CCS_CFG_TSRC 5
`define CCS_CFG_TEDGE 4
`define CCS_CFG_PSA 3
`define CCS_CFG_RATE_HI 2
`define CCS_CFG_RATE_LO 0
// Trim field positions
`define CCS_TRIM_CAL_HI 7
`define CCS_TRIM_CAL_LO 1
`define CCS_TRIM_CLKO 0
// Port pin numbers
`define CCS_PIN_CLK 2
// Instruction operation codes on the decoded op port
`define CCS_OP_NONE 3'h0
`define CCS_OP_JUMP 3'h1
`define CCS_OP_CALL 3'h2
`define CCS_OP_RETLIT 3'h3
`define CCS_OP_PCLWR 3'h4
`define CCS_OP_CFGLD 3'h5
// Instruction cycle clock divider (Fosc/4): core_clk is the oscillator
`define CCS_CLK_DIV 2'h3
`define CCS_CLK_HALF 2'h1
`endif

//--- hw/ccs_stack.v
// Two-level return address stack.
// Assumes push and pop come from the sequencer, never both at once.
`timescale 1ns/1ns
module ccs_stack #(
   parameter PCW = 9
) (
   // Clock, reset, enable
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   // Stack movement
   input wire push,
   input wire pop,
   input wire [PCW-1:0] push_data,
   // Top of stack
   output wire [PCW-1:0] top
);
   reg [PCW-1:0] level1; // Most recent return address
   reg [PCW-1:0] level2; // Older return address

   assign top = level1;

   // Push shifts down, pop shifts up; level 2 keeps its value on pop
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         level1 <= {PCW{1'b0}};
         level2 <= {PCW{1'b0}};
      end else if (clk_en) begin
         if (push) begin
            level2 <= level1;
            level1 <= push_data;
         end else if (pop) begin
            level1 <= level2;
         end
      end
   end
endmodule

//--- test/ccs_core_monitor.sv
// Checker for the core block: pc loading, literal return, config, trim.
// Assumes it is bound to ccs_core and sees only that module's ports.
`timescale 1ns/1ns
module ccs_core_mon #(
   parameter PCW = 9
) (
   // Clock, reset, enable
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   // Instruction and data bus
   input wire instr_step,
   input wire [2:0] instr_op,
   input wire [PCW-1:0] instr_target,
   input wire [7:0] work_reg,
   input wire [7:0] instr_literal,
   input wire data_wr,
   input wire [7:0] data_addr,
   input wire [7:0] data_wdata,
   input wire [3:0] pin_direction,
   // Watched outputs
   input wire [PCW-1:0] pc,
   input wire work_load,
   input wire [7:0] work_literal,
   input wire [3:0] pin_oe,
   input wire [3:0] pull_up_en,
   input wire [3:0] wake_en,
   input wire timer_source_select,
   input wire [2:0] prescaler_rate,
   input wire [3:0] timer_ratio_log2,
   input wire [3:0] watchdog_ratio_log2,
   input wire [6:0] trim_code,
   input wire clock_out_select
);
   // Instruction taken this edge; any data write is excluded, as a pc low byte write would override it
   wire go = clk_en && instr_step && !data_wr;
   // Write taken this edge
   wire wr = clk_en && data_wr;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_jump_load: assert property (go && instr_op == 3'h1
      |=> pc == $past(instr_target)) else $error("jump not loaded");
   a_call_clear: assert property (go && instr_op == 3'h2
      |=> pc == {1'b0, $past(instr_target[7:0])}) else $error("call pc bad");
   a_pc_step: assert property (go && instr_op == 3'h0
      |=> pc == $past(pc) + 1'b1) else $error("pc did not advance");
   a_pcl_write: assert property (wr && data_addr == 8'h02
      |=> pc == {1'b0, $past(data_wdata)}) else $error("pcl write bad");
   a_lit_return: assert property (go && instr_op == 3'h3
      |=> work_load && work_literal == $past(instr_literal))
      else $error("literal return bad");
   a_cfg_load: assert property (go && instr_op == 3'h5
      |=> timer_source_select == $past(work_reg[5])
      && prescaler_rate == $past(work_reg[2:0])
      && (pin_direction[1] -> wake_en[1] == !$past(work_reg[7])))
      else $error("config load bad");
   a_out_no_pull: assert property (!pin_direction[0]
      |-> !pull_up_en[0] && !wake_en[0]) else $error("output pin pulled");
   a_tsrc_input: assert property (timer_source_select
      && !clock_out_select |-> !pin_oe[2]) else $error("timer pin driven");
   a_ratio_map: assert property (timer_ratio_log2
      == {1'b0, prescaler_rate} + 4'h1
      && watchdog_ratio_log2 == {1'b0, prescaler_rate})
      else $error("ratio mismatch");
   a_trim_write: assert property (wr && data_addr == 8'h05
      |=> trim_code == $past(data_wdata[7:1])
      && clock_out_select == $past(data_wdata[0])) else $error("trim bad");
   a_clk_out: assert property (clock_out_select |-> pin_oe[2])
      else $error("clock out not driven");
endmodule

bind ccs_core ccs_core_mon #(.PCW(PCW)) u_mon (.*);

//--- test/tb_ccs_core.sv
// Testbench for the core block: reset, pc, stack, config and trim.
// Assumes ccs_core with PCW 9; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_ccs_core;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg clk_en = 1'b1;
   reg instr_step = 1'b0;
   reg [2:0] instr_op = 3'h0;
   reg [8:0] instr_target = 9'h000;
   reg [7:0] work_reg = 8'h00;
   reg [7:0] instr_literal = 8'h00;
   reg data_wr = 1'b0;
   reg [7:0] data_addr = 8'h00;
   reg [7:0] data_wdata = 8'h00;
   reg [3:0] pin_direction = 4'hF;
   reg [3:0] port_latch = 4'hA;
   reg [3:0] pin_in = 4'h5;
   wire [7:0] data_rdata, work_literal;
   wire [8:0] pc;
   wire [3:0] pin_out, pin_oe, pull_up_en, wake_en, pin_sync;
   wire [3:0] timer_ratio_log2, watchdog_ratio_log2;
   wire work_load, timer_source_select, timer_edge_select;
   wire prescaler_assign, timer_ext_clock, clock_out_select;
   wire [2:0] prescaler_rate;
   wire [6:0] trim_code;
   wire signed [7:0] trim_offset;
   integer bad_count = 0;
   integer checked = 0;
   integer k;
   reg p2;
   reg signed [7:0] o_hi, o_mid;

   ccs_core #(.PCW(9)) u_dut (.*);

   // 50 ns clock
   initial forever #25 core_clk = ~core_clk;

   task chk(input ok, input [8*16:1] msg);
      begin
         checked = checked + 1;
         if (!ok) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: %0s", $time, msg);
         end
      end
   endtask

   // Step held high between back-to-back ops; idle lowers it
   task exec(input [2:0] op, input [8:0] t, input [7:0] w);
      begin
         instr_op = op;
         instr_target = t;
         work_reg = w;
         instr_literal = w;
         instr_step = 1'b1;
         @(negedge core_clk);
      end
   endtask

   task idle;
      begin
         instr_step = 1'b0;
         instr_op = 3'h0;
         @(negedge core_clk);
      end
   endtask

   // Extra cycle after the write keeps data_addr stable for a read
   task wr(input [7:0] a, input [7:0] d);
      begin
         data_wr = 1'b1;
         data_addr = a;
         data_wdata = d;
         @(negedge core_clk);
         data_wr = 1'b0;
         @(negedge core_clk);
      end
   endtask

   task rd(input [7:0] a, input [7:0] e);
      begin
         data_addr = a;
         @(negedge core_clk);
         chk(data_rdata === e, "read");
      end
   endtask

   task report_and_stop;
      begin
         $display("checked %0d bad_count %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task t_reset;
      begin
         chk(pc === 9'h1FF, "pc reset");
         chk({timer_source_select, timer_edge_select, prescaler_assign,
            prescaler_rate} === 6'h3F, "cfg reset");
         chk(wake_en === 4'h0 && pull_up_en === 4'h0, "pins");
         rd(8'h05, 8'hFE);
         exec(3'h0, 9'h000, 8'h00);
         chk(pc === 9'h000, "pc wrap");
         $display("test reset done");
      end
   endtask

   task t_stack;
      begin
         exec(3'h1, 9'h1AB, 8'h00);
         chk(pc === 9'h1AB, "jump");
         exec(3'h2, 9'h1CD, 8'h00);
         chk(pc === 9'h0CD, "call");
         exec(3'h2, 9'h055, 8'h00);
         exec(3'h2, 9'h010, 8'h00);
         chk(pc === 9'h010, "call 3");
         exec(3'h3, 9'h000, 8'h5A);
         chk(pc === 9'h056 && work_load === 1'b1, "ret 1");
         chk(work_literal === 8'h5A, "literal");
         exec(3'h3, 9'h000, 8'h11);
         chk(pc === 9'h0CE, "ret 2");
         exec(3'h3, 9'h000, 8'h22);
         chk(pc === 9'h0CE, "ret 3");
         idle;
         idle;
         chk(pc === 9'h0CE && work_load === 1'b0, "hold");
         exec(3'h1, 9'h1F0, 8'h00);
         idle;
         wr(8'h02, 8'h77);
         chk(pc === 9'h077, "pcl write");
         rd(8'h02, 8'h77);
         $display("test stack done");
      end
   endtask

   task t_cfg;
      begin
         exec(3'h5, 9'h000, 8'h00);
         idle;
         chk(wake_en === 4'hB && pull_up_en === 4'hB, "en");
         chk({timer_source_select, timer_edge_select,
            prescaler_assign} === 3'h0, "cfg 0");
         pin_direction = 4'hA;
         @(negedge core_clk);
         chk(pull_up_en === 4'hA && wake_en === 4'hA, "out");
         chk(pin_oe[0] && pin_out[0] === port_latch[0], "drv");
         exec(3'h5, 9'h000, 8'hF8);
         chk({timer_source_select, timer_edge_select,
            prescaler_assign} === 3'h7, "cfg 1");
         chk(pin_oe[2] === 1'b0 && wake_en === 4'h0, "tsrc");
         for (k = 0; k < 8; k = k + 1) begin
            exec(3'h5, 9'h000, k);
            chk(timer_ratio_log2 === k + 1, "tmr");
            chk(watchdog_ratio_log2 === k, "wdt");
         end
         idle;
         chk(pin_sync === pin_in, "sync");
         $display("test cfg done");
      end
   endtask

   task t_trim;
      begin
         wr(8'h05, 8'h81);
         chk(trim_code === 7'h40 && clock_out_select, "trim");
         chk(pin_oe[2] === 1'b1, "clk pin");
         p2 = pin_out[2];
         repeat (2) @(negedge core_clk);
         chk(pin_out[2] === ~p2, "clk out");
         wr(8'h09, 8'h00);
         rd(8'h05, 8'h81);
         wr(8'h05, 8'h7E);
         o_hi = trim_offset;
         wr(8'h05, 8'h00);
         o_mid = trim_offset;
         wr(8'h05, 8'hFE);
         chk(o_hi > o_mid && o_mid > trim_offset, "cal");
         $display("test trim done");
      end
   endtask

   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      t_reset;
      t_stack;
      t_cfg;
      t_trim;
      report_and_stop;
   end

   // Tests need under 50 cycles; cut a hang at 2000
   initial begin
      #100000;
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule
